// ===== gpx_consts.svh
// register offsets, field positions, reset values and timing for the port 6 gpio block
// ==========================================================================
`ifndef GPX_CONSTS_SVH
`define GPX_CONSTS_SVH
// ==========================================================================
// byte addresses
`define GPX_ADDR_W 32
`define GPX_OFS_CFG 32'hFFF83060
`define GPX_OFS_DIR 32'hFFF83064
`define GPX_OFS_DOUT 32'hFFF83068
`define GPX_OFS_DIN 32'hFFF8306C
`define GPX_OFS_DBNC 32'hFFF83070
`define GPX_OFS_XCFG 32'hFFF83074
`define GPX_OFS_XSTAT 32'hFFF83078
// ==========================================================================
// field positions
`define GPX_PINS 12
`define GPX_OE_LSB 0
`define GPX_PU_LSB 16
`define GPX_DBSEL_LSB 4
`define GPX_DBSEL_W 3
`define GPX_FUNC_GPIO 2'h0
`define GPX_TRIG_LOW 2'h0
`define GPX_TRIG_HIGH 2'h1
`define GPX_TRIG_FALL 2'h2
`define GPX_TRIG_RISE 2'h3
`define GPX_IRQ_CHANNEL 31
// ==========================================================================
// reset values and filter length
`define GPX_RST_ZERO 32'h00000000
`define GPX_FILTER_SAMPLES 3
`endif

// ===== gpx_pkg.sv
// types shared by the port 6 gpio block
`default_nettype none
package gpx_pkg;
    // one extended interrupt's configuration nibble
    typedef struct packed {
        logic enable;
        logic filter_en;
        logic [1:0] trig;
    } gpx_xcfg_type;
    // register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } gpx_req_type;
    // state of a debounce filter
    typedef enum logic [1:0] {
        GPX_F_IDLE = 2'b00,
        GPX_F_COUNT = 2'b01
    } gpx_filt_type;
endpackage
`default_nettype wire

// ===== gpx_debounce.sv
// shared debounce divider and per-input filters
`default_nettype none
`include "gpx_consts.svh"
module gpx_debounce #(
    parameter int N = 6,
    parameter int SAMPLES = `GPX_FILTER_SAMPLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic [2:0] div_sel,
    input wire logic [N-1:0] filter_en,
    // inputs and filtered outputs
    input wire logic [N-1:0] raw,
    output logic [N-1:0] clean
);
    // free running divider; bit k toggles at clk/2^(k+1)
    logic [7:0] div_r;
    logic tick_r;
    logic [N-1:0] stable_r;
    logic [1:0] cnt_r [N];
    // sample tick once per 2^div_sel clocks
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_r <= 8'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            div_r <= div_r + 8'h01;
            tick_r <= ((div_r & ((8'h01 << div_sel) - 8'h01)) == 8'h00);
        end
    end
    // a new level is accepted after SAMPLES equal ticks; bypassed when off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // inputs idle high, so no false level or edge follows reset
            stable_r <= '1;
            for (int i = 0; i < N; i++)
                cnt_r[i] <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (!filter_en[i])
                begin
                    stable_r[i] <= raw[i];
                    cnt_r[i] <= 2'h0;
                end
                else if (raw[i] == stable_r[i])
                    cnt_r[i] <= 2'h0;
                else if (tick_r)
                begin
                    if (cnt_r[i] == 2'(SAMPLES - 1))
                    begin
                        stable_r[i] <= raw[i];
                        cnt_r[i] <= 2'h0;
                    end
                    else
                        cnt_r[i] <= cnt_r[i] + 2'h1;
                end
            end
        end
    end
    assign clean = stable_r;
endmodule
`default_nettype wire

// ===== gpx_edge.sv
// trigger detector for one extended interrupt
`default_nettype none
`include "gpx_consts.svh"
module gpx_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filtered level and trigger type
    input wire logic level,
    input wire logic [1:0] trig,
    // one cycle per detected condition, or held for levels
    output logic hit
);
    logic prev_r;
    // previous level for edge compare
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= 1'b1;
        else
            prev_r <= level;
    end
    // trigger select
    always_comb
    begin
        case (trig)
            `GPX_TRIG_LOW: hit = !level;
            `GPX_TRIG_HIGH: hit = level;
            `GPX_TRIG_FALL: hit = prev_r && !level;
            `GPX_TRIG_RISE: hit = !prev_r && level;
            default: hit = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== gpx_port6.sv
// port 6 gpio with debounced external requests and extended interrupts
//
// Added by the designer: the plain strobed port.
`default_nettype none
`include "gpx_consts.svh"
module gpx_port6 #(
    parameter int PINS = `GPX_PINS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // port pins
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_pullup,
    // external request inputs and wait pin
    input wire logic [3:0] external_request_n,
    input wire logic wait_request_pin_n,
    // filtered request levels to the rest of the chip
    output logic [3:0] request_filtered_n,
    // interrupt controller channel request
    output logic irq_channel_req
);
    // ======================================================================
    // reset synchroniser
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ======================================================================
    // registers
    logic [2*PINS-1:0] func_sel_r; // pin_function_select
    logic [PINS-1:0] output_enable_bits_r;
    logic [PINS-1:0] pullup_enable_bits_r;
    logic [PINS-1:0] output_value_bits_r;
    logic [2:0] debounce_divider_select_r;
    logic [3:0] request_filter_enable_r;
    gpx_pkg::gpx_xcfg_type xcfg_a_r; // extended interrupt a (pin 0)
    gpx_pkg::gpx_xcfg_type xcfg_b_r; // extended interrupt b (wait pin)
    logic ext_irq_a_flag_r;
    logic ext_irq_b_flag_r;
    logic [PINS-1:0] pin_level_r; // sampled pin levels
    gpx_pkg::gpx_req_type req;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // decode helper used by every write and read
    function automatic logic hit_addr(input logic [31:0] a, input logic [31:0] ofs);
        hit_addr = (a == ofs);
    endfunction

    // configuration writes
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            func_sel_r <= '0;
            output_enable_bits_r <= '0;
            pullup_enable_bits_r <= '0;
            output_value_bits_r <= '0;
            debounce_divider_select_r <= 3'h0;
            request_filter_enable_r <= 4'h0;
            xcfg_a_r <= '0;
            xcfg_b_r <= '0;
        end
        else if (req.wr)
        begin
            if (hit_addr(req.addr, `GPX_OFS_CFG))
                func_sel_r <= req.wdata[2*PINS-1:0];
            if (hit_addr(req.addr, `GPX_OFS_DIR))
            begin
                output_enable_bits_r <= req.wdata[`GPX_OE_LSB +: PINS];
                pullup_enable_bits_r <= req.wdata[`GPX_PU_LSB +: PINS];
            end
            if (hit_addr(req.addr, `GPX_OFS_DOUT))
                output_value_bits_r <= req.wdata[PINS-1:0];
            if (hit_addr(req.addr, `GPX_OFS_DBNC))
            begin
                debounce_divider_select_r <= req.wdata[`GPX_DBSEL_LSB +: `GPX_DBSEL_W];
                request_filter_enable_r <= req.wdata[3:0];
            end
            if (hit_addr(req.addr, `GPX_OFS_XCFG))
            begin
                xcfg_b_r <= req.wdata[7:4];
                xcfg_a_r <= req.wdata[3:0];
            end
        end
    end

    // ======================================================================
    // pin drive: enable only in gpio function
    logic [PINS-1:0] gpio_mode;
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
            gpio_mode[i] = (func_sel_r[2*i +: 2] == `GPX_FUNC_GPIO);
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pin_out <= '0;
            pin_oe <= '0;
            pin_pullup <= '0;
            pin_level_r <= '0;
        end
        else
        begin
            pin_oe <= output_enable_bits_r & gpio_mode;
            pin_out <= output_value_bits_r;
            pin_pullup <= pullup_enable_bits_r;
            pin_level_r <= pin_in;
        end
    end

    // ======================================================================
    // shared debouncer: four requests, then interrupt a, then b
    logic [5:0] raw_levels;
    logic [5:0] clean_levels;
    assign raw_levels = {wait_request_pin_n, pin_in[0], external_request_n};
    gpx_debounce #(.N(6), .SAMPLES(`GPX_FILTER_SAMPLES)) u_dbnc (
        .clk(ref_clk),
        .rst_n(rst_n_r),
        .div_sel(debounce_divider_select_r),
        .filter_en({xcfg_b_r.filter_en, xcfg_a_r.filter_en, request_filter_enable_r}),
        .raw(raw_levels),
        .clean(clean_levels)
    );

    // trigger detection for each extended interrupt
    logic hit_a;
    logic hit_b;
    gpx_edge u_edge_a (
        .clk(ref_clk),
        .rst_n(rst_n_r),
        .level(clean_levels[4]),
        .trig(xcfg_a_r.trig),
        .hit(hit_a)
    );
    gpx_edge u_edge_b (
        .clk(ref_clk),
        .rst_n(rst_n_r),
        .level(clean_levels[5]),
        .trig(xcfg_b_r.trig),
        .hit(hit_b)
    );

    // ======================================================================
    // sticky flags: write zero clears, a same-cycle hit wins
    logic clr_a;
    logic clr_b;
    assign clr_a = req.wr && hit_addr(req.addr, `GPX_OFS_XSTAT) && !req.wdata[0];
    assign clr_b = req.wr && hit_addr(req.addr, `GPX_OFS_XSTAT) && !req.wdata[1];
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            ext_irq_a_flag_r <= 1'b0;
            ext_irq_b_flag_r <= 1'b0;
        end
        else
        begin
            if (hit_a)
                ext_irq_a_flag_r <= 1'b1;
            else if (clr_a)
                ext_irq_a_flag_r <= 1'b0;
            if (hit_b)
                ext_irq_b_flag_r <= 1'b1;
            else if (clr_b)
                ext_irq_b_flag_r <= 1'b0;
        end
    end

    // ======================================================================
    // wired-or channel request and filtered request levels
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            irq_channel_req <= 1'b0;
            request_filtered_n <= 4'hF;
        end
        else
        begin
            irq_channel_req <= (xcfg_a_r.enable && ext_irq_a_flag_r)
                || (xcfg_b_r.enable && ext_irq_b_flag_r);
            request_filtered_n <= clean_levels[3:0];
        end
    end

    // ======================================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            reg_rdata <= `GPX_RST_ZERO;
        else if (req.rd)
        begin
            reg_rdata <= `GPX_RST_ZERO;
            if (hit_addr(req.addr, `GPX_OFS_CFG))
                reg_rdata <= 32'(func_sel_r);
            else if (hit_addr(req.addr, `GPX_OFS_DIR))
                reg_rdata <= (32'(pullup_enable_bits_r) << `GPX_PU_LSB)
                    | 32'(output_enable_bits_r);
            else if (hit_addr(req.addr, `GPX_OFS_DOUT))
                reg_rdata <= 32'(output_value_bits_r);
            else if (hit_addr(req.addr, `GPX_OFS_DIN))
                reg_rdata <= 32'(pin_level_r);
            else if (hit_addr(req.addr, `GPX_OFS_DBNC))
                reg_rdata <= {25'h0, debounce_divider_select_r, request_filter_enable_r};
            else if (hit_addr(req.addr, `GPX_OFS_XCFG))
                reg_rdata <= {24'h0, xcfg_b_r, xcfg_a_r};
            else if (hit_addr(req.addr, `GPX_OFS_XSTAT))
                reg_rdata <= {30'h0, ext_irq_b_flag_r, ext_irq_a_flag_r};
        end
        else
            reg_rdata <= `GPX_RST_ZERO;
    end
endmodule
`default_nettype wire

// ===== gpx_port6_checker.sv
// concurrent checks on the port 6 gpio block, bound to its top ports
`default_nettype none
`include "gpx_consts.svh"
module gpx_port6_checker #(
    parameter int PINS = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins and requests
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pin_pullup,
    input wire logic [3:0] external_request_n,
    input wire logic [3:0] request_filtered_n,
    input wire logic irq_channel_req
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================================
    // helpers
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    wire logic w_dout = reg_wr && (reg_addr == `GPX_OFS_DOUT);
    wire logic w_dir = reg_wr && (reg_addr == `GPX_OFS_DIR);
    wire logic w_cfg = reg_wr && (reg_addr == `GPX_OFS_CFG);
    wire logic w_xcfg = reg_wr && (reg_addr == `GPX_OFS_XCFG);
    // high while every request filter is switched off, mirrors the control write
    logic byp_r;
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            byp_r <= 1'b1;
        else if (reg_wr && (reg_addr == `GPX_OFS_DBNC))
            byp_r <= (reg_wdata[3:0] == 4'h0);
    // ==========================================================================
    // assertions
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_din_reserved: assert property ($past(reg_rd) && $past(reg_addr) == `GPX_OFS_DIN
        |-> reg_rdata[31:12] == 20'h0) else $error("input data reserved bits set");
    // the value register and the pin flop add one edge each
    a_dout_load: assert property (w_dout |-> ##2 pin_out == $past(reg_wdata[11:0], 2))
        else $error("output value not loaded");
    a_dout_hold: assert property (!w_dout |-> ##2 $stable(pin_out))
        else $error("output value moved without a write");
    a_pullup_load: assert property (w_dir |-> ##2 pin_pullup == $past(reg_wdata[27:16], 2))
        else $error("pull-up enables not loaded");
    a_oe_gated: assert property (w_cfg && reg_wdata[1:0] != 2'h0 |-> ##2 !pin_oe[0])
        else $error("pin drives outside gpio function");
    a_irq_off: assert property (w_xcfg && !reg_wdata[7] && !reg_wdata[3]
        |-> ##2 !irq_channel_req) else $error("channel request with both disabled");
    a_bypass_pass: assert property (byp_r && $stable(external_request_n)[*5]
        |-> request_filtered_n == external_request_n) else $error("bypass level wrong");
    // ==========================================================================
    // covers
    c_irq_up: cover property ($rose(irq_channel_req));
    c_din_read: cover property ($past(reg_rd) && $past(reg_addr) == `GPX_OFS_DIN);
    c_filtered: cover property (!byp_r && $changed(request_filtered_n));
endmodule
`default_nettype wire

// ===== gpx_pin_model.sv
// board side of the port pins: drivers, pull-ups and floating lines
`default_nettype none
module gpx_pin_model #(
    parameter int PINS = 12
) (
    // clock
    input wire logic ref_clk,
    // block side
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pin_pullup,
    // board drivers
    input wire logic [PINS-1:0] ext_val,
    input wire logic [PINS-1:0] ext_drv,
    // resolved level
    output logic [PINS-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // a floating line toggles so an unknown never settles by luck
    logic flip_r;
    initial flip_r = 1'b0;
    always @(posedge ref_clk)
        flip_r <= ~flip_r;
    // block driver first, then board driver, then pull-up, else floating
    always_comb
        for (int i = 0; i < PINS; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i]
                : pin_pullup[i] ? 1'b1 : flip_r;
endmodule
`default_nettype wire

// ===== gpx_port6_bench.sv
// self-checking bench for the port 6 gpio block
`default_nettype none
`include "gpx_consts.svh"
module gpx_port6_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================================
    // signals
    logic ref_clk, arst_n, reg_wr, reg_rd, wait_request_pin_n, irq_channel_req;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [11:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val, ext_drv;
    logic [3:0] external_request_n, request_filtered_n;
    int miscompares, n_checks, cycles;
    gpx_port6 dut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pin_in, .pin_out, .pin_oe, .pin_pullup, .external_request_n, .wait_request_pin_n,
        .request_filtered_n, .irq_channel_req);
    gpx_pin_model pins (.ref_clk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_drv,
        .pin_in);
    // ==========================================================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic src(input int w, input logic v);
        if (w == 0)
            ext_val[0] <= v;
        else
            wait_request_pin_n <= v;
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================================
    // clock and hang guard
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
    // ==========================================================================
    // tests
    initial
    begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        // board holds every pin high, so pin 0 never floats into a level trigger
        {ext_val, ext_drv, external_request_n, wait_request_pin_n} = '1;
        idle(8);
        arst_n <= 1'b1;
        idle(4);
        // reset values, unmapped slot at the end reads zero
        for (int i = 0; i < 8; i++)
            if (i != 3)
                rd(`GPX_OFS_CFG + 32'(4 * i), 32'h0);
        wr(`GPX_OFS_DIR, 32'h0FFF0FFF);
        wr(`GPX_OFS_DOUT, 32'hFFFFFABC);
        rd(`GPX_OFS_DOUT, 32'h00000ABC);
        chk({20'h0, pin_out}, 32'h00000ABC);
        chk({20'h0, pin_oe}, 32'h00000FFF);
        chk({20'h0, pin_pullup}, 32'h00000FFF);
        rd(`GPX_OFS_DIN, 32'h00000ABC);
        wr(`GPX_OFS_CFG, 32'h00000001);
        rd(`GPX_OFS_CFG, 32'h00000001);
        chk({20'h0, pin_oe}, 32'h00000FFE);
        wr(`GPX_OFS_DIR, 32'h0);
        ext_drv <= 12'hFFF;
        ext_val <= 12'h5A5;
        idle(4);
        wr(`GPX_OFS_DIN, 32'hFFFFFFFF);
        rd(`GPX_OFS_DIN, 32'h000005A5);
        // every trigger type on both extended interrupts
        for (int w = 0; w < 2; w++)
            for (int t = 0; t < 4; t++)
            begin
                if (w == 1)
                    ext_val[0] <= 1'b1;
                src(w, ~t[0]);
                idle(6);
                wr(`GPX_OFS_XCFG, 32'({2'b10, t[1:0]}) << (4 * w));
                wr(`GPX_OFS_XSTAT, 32'h0);
                idle(6);
                rd(`GPX_OFS_XSTAT, 32'h0);
                src(w, t[0]);
                idle(6);
                rd(`GPX_OFS_XSTAT, 32'h1 << w);
                chk({31'h0, irq_channel_req}, 32'h1);
                wr(`GPX_OFS_XSTAT, 32'h3);
                rd(`GPX_OFS_XSTAT, 32'h1 << w);
                src(w, ~t[0]);
                idle(6);
                wr(`GPX_OFS_XSTAT, 32'h0);
                rd(`GPX_OFS_XSTAT, 32'h0);
                chk({31'h0, irq_channel_req}, 32'h0);
            end
        // request filters at two sample rates, divider select 1 then 3
        wr(`GPX_OFS_DBNC, 32'h0000001F);
        external_request_n <= 4'h0;
        idle(3);
        chk({28'h0, request_filtered_n}, 32'h0000000F);
        idle(20);
        chk({28'h0, request_filtered_n}, 32'h0);
        wr(`GPX_OFS_DBNC, 32'h0000003F);
        external_request_n <= 4'hF;
        idle(12);
        chk({28'h0, request_filtered_n}, 32'h0);
        idle(60);
        chk({28'h0, request_filtered_n}, 32'h0000000F);
        // a short glitch on a filtered extended interrupt is swallowed
        // wait pin back high first, else its low-level default sets flag b
        wait_request_pin_n <= 1'b1;
        wr(`GPX_OFS_XCFG, 32'h0000000F);
        wr(`GPX_OFS_XSTAT, 32'h0);
        ext_val[0] <= 1'b0;
        idle(3);
        ext_val[0] <= 1'b1;
        idle(60);
        rd(`GPX_OFS_XSTAT, 32'h0);
        // both interrupts disabled: the channel request must stay low
        wr(`GPX_OFS_XCFG, 32'h0);
        wr(`GPX_OFS_DBNC, 32'h0);
        external_request_n <= 4'h5;
        idle(6);
        report_and_stop();
    end
endmodule
bind gpx_port6 gpx_port6_checker #(.PINS(PINS)) u_chk (.ref_clk, .arst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_out, .pin_oe, .pin_pullup,
    .external_request_n, .request_filtered_n, .irq_channel_req);
`default_nettype wire
